// File: pcmhw_pkg.sv
// shared constants and types of the pcm highway slot port
`default_nettype none
package pcmhw_pkg;
  // ****************************************
  // widths and depths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  // ****************************************
  // frame timing
  // ****************************************
  // generated frame length in bit clocks when this port is timing master
  localparam int FRAME_LEN = 32;
  // least spacing of successive frame sync pulses, in bit clocks
  localparam int MIN_SYNC_GAP = 16;
  // ****************************************
  // reset and idle values
  // ****************************************
  localparam logic [DATA_W-1:0] IDLE_WORD = 8'hFF;
  localparam logic [DATA_W-1:0] WORD_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 8'hFF;
  typedef enum logic {TX_IDLE, TX_DRIVE} pcmhw_tx_state_t;
endpackage
`default_nettype wire

// File: pcmhw_sync2.sv
// two flip-flop level synchroniser
`default_nettype none
module pcmhw_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// File: pcmhw_fifo.sv
// synchronous fifo with valid and ready on both sides
`default_nettype none
module pcmhw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // storage has no reset; only entries below the count are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: pcmhw_slot_port.sv
// pcm highway time slot port: user side on ref_clk, highway side on pcm_clk
`default_nettype none
module pcmhw_slot_port #(
  parameter int DATA_W = pcmhw_pkg::DATA_W,
  parameter int FIFO_DEPTH = pcmhw_pkg::FIFO_DEPTH,
  parameter int FRAME_LEN = pcmhw_pkg::FRAME_LEN
) (
  // system clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // highway bit clock
  input wire logic pcm_clk,
  // static configuration
  input wire logic timing_master,
  input wire logic [pcmhw_pkg::CNT_W-1:0] slot_start,
  // transmit words from the user
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  // received words to the user
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  // frame sync pin
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  // data pins
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic txd_weak_oe,
  // open-drain slot strobe, active low on the wire
  output logic slot_active_strobe_out,
  output logic slot_active_strobe_oe
);
  import pcmhw_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (DATA_W < 2 || DATA_W > 2**CNT_W) begin : g_bad_width
    $error("slot width out of range");
  end
  if (FRAME_LEN < MIN_SYNC_GAP || FRAME_LEN > 2**CNT_W) begin : g_bad_frame
    $error("frame length out of range");
  end
  localparam logic [CNT_W-1:0] LAST_OFF = CNT_W'(DATA_W - 1);
  localparam logic [CNT_W-1:0] FRAME_END = CNT_W'(FRAME_LEN - 1);

  // ****************************************
  // user side: fifo and word handshake
  // ****************************************
  logic fifo_valid, fifo_pop;
  logic [DATA_W-1:0] fifo_data;
  logic [DATA_W-1:0] word_reg, word_next, rx_data_reg, rx_data_next;
  logic req_reg, req_next, ack_s, rx_tog_s, rx_seen_reg, rx_seen_next, rx_valid_reg, rx_valid_next;
  logic ack_reg, rx_tog_reg;
  logic [DATA_W-1:0] rx_word_reg;

  pcmhw_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  pcmhw_sync2 #(.W(2)) u_sync_ref (
    .clk(ref_clk),
    .rst_b(rst_b),
    .d({ack_reg, rx_tog_reg}),
    .q({ack_s, rx_tog_s})
  );

  // the holding word stays stable until the link acknowledges it
  assign fifo_pop = (req_reg == ack_s);
  always_comb begin
    word_next = word_reg;
    req_next = req_reg;
    if (fifo_pop && fifo_valid) begin
      word_next = fifo_data;
      req_next = ~req_reg;
    end
    rx_seen_next = rx_tog_s;
    rx_valid_next = (rx_tog_s != rx_seen_reg);
    rx_data_next = rx_valid_next ? rx_word_reg : rx_data_reg;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_reg <= WORD_RST;
      req_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_data_reg <= WORD_RST;
    end else begin
      word_reg <= word_next;
      req_reg <= req_next;
      rx_seen_reg <= rx_seen_next;
      rx_valid_reg <= rx_valid_next;
      rx_data_reg <= rx_data_next;
    end
  end
  assign rx_valid = rx_valid_reg;
  assign rx_data = rx_data_reg;

  // ****************************************
  // link side, rising edge: launch and master sync
  // ****************************************
  logic master_s, req_s;
  logic [CNT_W-1:0] start_s;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  pcmhw_sync2 #(.W(CNT_W + 2)) u_sync_link (
    .clk(pcm_clk),
    .rst_b(rst_b),
    .d({timing_master, req_reg, slot_start}),
    .q({master_s, req_s, start_s})
  );

  pcmhw_tx_state_t tx_state_reg, tx_state_next;
  logic [DATA_W-1:0] shift_reg, shift_next;
  logic last_reg, last_next, ack_next, seq_reg, seq_next, fs_out_reg, fs_out_next;
  logic [CNT_W-1:0] mcnt_reg, mcnt_next, idx_reg;
  logic [CNT_W-1:0] tx_off;
  logic tx_in_slot, drive;
  logic weak_reg, weak_next, weak_seq_reg, weak_seq_next, weak_act;

  assign tx_off = cnt_reg - start_s;
  // launch index counts from the last accepted frame sync
  // slot position select
  assign tx_in_slot = (cnt_reg >= start_s) && (tx_off <= LAST_OFF);
  always_comb begin
    tx_state_next = TX_IDLE;
    shift_next = shift_reg;
    last_next = 1'b0;
    ack_next = ack_reg;
    if (tx_in_slot) begin
      tx_state_next = TX_DRIVE;
      last_next = (tx_off == LAST_OFF);
      if (tx_off == '0) begin
        shift_next = (req_s != ack_reg) ? word_reg : IDLE_WORD;
        ack_next = req_s;
      end else begin
        shift_next = {shift_reg[DATA_W-2:0], 1'b1};
      end
    end
    seq_next = ~seq_reg;
    mcnt_next = (mcnt_reg == FRAME_END) ? '0 : mcnt_reg + 1'b1;
    fs_out_next = master_s && (mcnt_reg == FRAME_END);
  end
  // disable one clock after last bit
  always_ff @(posedge pcm_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg <= TX_IDLE;
      shift_reg <= IDLE_WORD;
      last_reg <= 1'b0;
      ack_reg <= 1'b0;
      seq_reg <= 1'b0;
      mcnt_reg <= '0;
      fs_out_reg <= 1'b0;
      idx_reg <= '0;
    end else begin
      tx_state_reg <= tx_state_next;
      shift_reg <= shift_next;
      last_reg <= last_next;
      ack_reg <= ack_next;
      seq_reg <= seq_next;
      mcnt_reg <= mcnt_next;
      fs_out_reg <= fs_out_next;
      idx_reg <= cnt_reg;
    end
  end

  // ****************************************
  // link side, falling edge: sync, receive, weak hold
  // ****************************************
  logic fs_seen, rx_in_slot, rx_tog_next;
  logic [CNT_W-1:0] rx_off;
  logic [DATA_W-1:0] rx_shift_reg, rx_shift_next, rx_word_next;

  assign fs_seen = master_s ? fs_out_reg : frame_sync_in;
  assign rx_off = cnt_reg - start_s;
  assign rx_in_slot = (cnt_reg >= start_s) && (rx_off <= LAST_OFF);
  assign drive = (tx_state_reg == TX_DRIVE);
  always_comb begin
    if (fs_seen) begin
      cnt_next = '0;
    end else begin
      cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 1'b1;
    end
    rx_shift_next = rx_shift_reg;
    rx_word_next = rx_word_reg;
    rx_tog_next = rx_tog_reg;
    if (rx_in_slot) begin
      rx_shift_next = {rx_shift_reg[DATA_W-2:0], rxd_in};
      if (rx_off == LAST_OFF) begin
        rx_word_next = rx_shift_next;
        rx_tog_next = ~rx_tog_reg;
      end
    end
    // weak hold from mid last bit
    weak_next = drive && last_reg;
    weak_seq_next = seq_reg;
  end
  always_ff @(negedge pcm_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= CNT_RST;
      rx_shift_reg <= WORD_RST;
      rx_word_reg <= WORD_RST;
      rx_tog_reg <= 1'b0;
      weak_reg <= 1'b0;
      weak_seq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rx_shift_reg <= rx_shift_next;
      rx_word_reg <= rx_word_next;
      rx_tog_reg <= rx_tog_next;
      weak_reg <= weak_next;
      weak_seq_reg <= weak_seq_next;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // weak hold expires by itself at the next rising edge, when seq moves on
  assign weak_act = weak_reg && (weak_seq_reg == seq_reg);
  assign txd_oe = drive && !weak_act;
  assign txd_weak_oe = drive && weak_act;
  assign txd_out = shift_reg[DATA_W-1];
  assign slot_active_strobe_out = 1'b0;
  // strobe drops after last falling edge
  assign slot_active_strobe_oe = drive && !weak_act;
  assign frame_sync_out = fs_out_reg;
  assign frame_sync_oe = master_s;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_sync_pulse;
    frame_sync_out ##1 !frame_sync_out;
  endsequence
  a_strong_first_half: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    drive && last_reg |-> txd_oe && !txd_weak_oe) else $error("last bit not strong in first half");
  a_weak_second_half: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    drive && last_reg |-> txd_weak_oe && !txd_oe) else $error("last bit not weak in second half");
  a_weak_release: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    txd_weak_oe |=> !txd_weak_oe) else $error("weak hold longer than half bit");
  a_strobe_open_drain: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    !slot_active_strobe_out) else $error("strobe driven high");
  a_launch_at_start: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    $rose(drive) |-> idx_reg == start_s) else $error("transmit began off slot start");
  a_slave_sync_sample: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    !master_s && frame_sync_in |=> cnt_reg == '0) else $error("frame sync not taken");
  a_rx_word_done: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    rx_in_slot && rx_off == LAST_OFF |=> rx_tog_reg != $past(rx_tog_reg)) else $error("rx word lost");
  a_master_sync: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    master_s && mcnt_reg == FRAME_END |=> s_sync_pulse) else $error("bad master sync pulse");
  a_strobe_window: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    drive |-> slot_active_strobe_oe ##1 (last_reg || !drive || slot_active_strobe_oe))
    else $error("strobe missing in slot");
  a_tx_disable: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    drive && last_reg && !tx_in_slot |=> !drive && !txd_oe) else $error("transmitter not disabled");
  a_slot_bounds: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    drive |-> idx_reg >= start_s && (idx_reg - start_s) <= LAST_OFF) else $error("drive outside slot");
  a_weak_in_slot: assert property (@(negedge pcm_clk) disable iff (!rst_b)
    txd_weak_oe |-> drive) else $error("weak drive outside slot");
  a_idle_released: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    !drive |-> !txd_oe && !txd_weak_oe) else $error("line driven while idle");
  a_sync_one_bit: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    frame_sync_out |=> !frame_sync_out) else $error("master sync wider than one bit");
  a_strobe_idle_off: assert property (@(posedge pcm_clk) disable iff (!rst_b)
    !drive |-> !slot_active_strobe_oe) else $error("strobe active outside slot");
  a_rx_single_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_valid |=> !rx_valid) else $error("receive pulse wider than one cycle");
endmodule
`default_nettype wire

// File: pcmhw_hw_model.sv
// partner model: highway bit clock, frame sync source, far talker and listener
`default_nettype none
module pcmhw_hw_model #(
  parameter int FRAME = 32,
  parameter int START = 20
) (
  // control
  input wire logic rst_b,
  input wire logic master,
  input wire logic [7:0] rx_word,
  // highway pins
  output logic pcm_clk,
  output logic frame_sync_in,
  output logic rxd_in,
  input wire logic frame_sync_out,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic txd_weak_oe,
  input wire logic strb_out,
  input wire logic strb_oe,
  // results
  output logic [7:0] got_word,
  output int got_cnt,
  output int bad_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int fcnt = 0;
  int pos = 255;
  int settle = 0;
  logic last_bit = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    pcm_clk = 0;
    frame_sync_in = 0;
    rxd_in = 0;
    got_word = 8'h00;
    got_cnt = 0;
    bad_cnt = 0;
  end
  // ****
  // timing source and talker
  // ****
  always #32 pcm_clk = ~pcm_clk;
  always @(posedge pcm_clk) begin
    fcnt = (fcnt + 1) % FRAME;
    frame_sync_in <= !master && fcnt == 0;
    if (pos >= START && pos < START + 8)
      rxd_in <= rx_word[START + 7 - pos];
    else
      rxd_in <= ~rxd_in;
  end
  // ****
  // listener
  // ****
  // sample on fall, never drive
  always @(negedge pcm_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos = 255;
      settle = 0;
      last_bit = 0;
    end else begin
      last_bit = pos == START + 7;
      if (pos >= START && pos < START + 8) begin
        if ({txd_oe, strb_oe, strb_out} !== 3'b110)
          bad_cnt++;
        sh = {sh[6:0], txd_out};
        if (last_bit) begin
          got_word = sh;
          got_cnt++;
        end
      end else if (pos < 255 && {txd_oe, txd_weak_oe, strb_oe} !== 3'b000) begin
        bad_cnt++;
      end
      settle = settle < 4 ? settle + 1 : 4;
      if (settle >= 4 && (master ? frame_sync_out : frame_sync_in))
        pos = 0;
      else
        pos = pos < 255 ? pos + 1 : 255;
    end
  end
  always @(negedge pcm_clk) begin
    #4;
    if (last_bit && {txd_oe, txd_weak_oe, strb_oe, txd_out} !== {3'b010, got_word[0]})
      bad_cnt++;
  end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench of the pcm highway slot port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcmhw_pkg::*;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic tm = 0;
  logic tx_valid = 0;
  logic [DATA_W-1:0] tx_data = 8'h00;
  logic [DATA_W-1:0] rx_word = 8'hA5;
  logic [CNT_W-1:0] slot_start = 8'h14;
  wire logic pcm_clk, tx_ready, rx_valid, fs_in, fs_out, fs_oe, rxd, txd, txd_oe, weak_oe, strb, strb_oe;
  wire logic [DATA_W-1:0] rx_data;
  logic [7:0] got_word;
  int got_cnt, bad_cnt;
  int n_errors = 0;
  int total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  pcmhw_slot_port i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .pcm_clk(pcm_clk), .timing_master(tm), .slot_start(slot_start),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .frame_sync_in(fs_in), .frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .rxd_in(rxd), .txd_out(txd),
    .txd_oe(txd_oe), .txd_weak_oe(weak_oe), .slot_active_strobe_out(strb), .slot_active_strobe_oe(strb_oe)
  );
  pcmhw_hw_model #(.FRAME(FRAME_LEN), .START(20)) i_hw (
    .rst_b(rst_b), .master(tm), .rx_word(rx_word), .pcm_clk(pcm_clk), .frame_sync_in(fs_in),
    .rxd_in(rxd), .frame_sync_out(fs_out), .txd_out(txd), .txd_oe(txd_oe), .txd_weak_oe(weak_oe),
    .strb_out(strb), .strb_oe(strb_oe), .got_word(got_word), .got_cnt(got_cnt), .bad_cnt(bad_cnt)
  );
  // ****
  // shared tasks
  // ****
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic timeout(input string what);
    $display("wrong value %s expected done seen timeout", what);
    n_errors++;
    stop_test();
  endtask
  task automatic wait_word(input logic [7:0] exp);
    int c;
    c = got_cnt;
    for (int i = 0; i < 4000 && got_cnt == c; i++)
      @(negedge ref_clk);
    if (got_cnt == c)
      timeout("highway word");
    check("highway word", {24'h0, exp}, {24'h0, got_word});
  endtask
  task automatic wait_rx(input logic [7:0] exp);
    int i;
    for (i = 0; i < 4000 && rx_valid !== 1'b1; i++)
      @(negedge ref_clk);
    if (i == 4000)
      timeout("rx pulse");
    check("rx word", {24'h0, exp}, {24'h0, rx_data});
    @(negedge ref_clk);
    check("rx pulse width", 0, {31'h0, rx_valid});
  endtask
  task automatic do_reset(input logic master);
    // let a weak half bit in progress end before the pins are reset
    @(posedge pcm_clk);
    @(negedge ref_clk);
    rst_b = 0;
    tm = master;
    repeat (2) @(posedge pcm_clk);
    check("ready in reset", 1, {31'h0, tx_ready});
    check("outputs in reset", 0, {27'h0, txd_oe, weak_oe, strb_oe, fs_out, rx_valid});
    @(negedge ref_clk);
    rst_b = 1;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_fill;
    int n;
    n = 0;
    wait_word(8'hFF);
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      tx_valid = tx_ready;
      tx_data = 8'h10 + n[7:0];
      n += tx_ready;
    end
    check("words taken", 17, n);
    tx_valid = 1;
    tx_data = 8'hEE;
    repeat (4) @(negedge ref_clk);
    check("ready when full", 0, {31'h0, tx_ready});
    tx_valid = 0;
    for (int i = 0; i < 17; i++)
      wait_word(8'h10 + i[7:0]);
    wait_word(8'hFF);
    check("ready after drain", 1, {31'h0, tx_ready});
  endtask
  task automatic t_master;
    int last;
    last = -1;
    rx_word = 8'h96;
    do_reset(1'b1);
    for (int i = 0; i < 100; i++) begin
      @(negedge pcm_clk);
      if (fs_out === 1'b1) begin
        if (last >= 0)
          check("sync spacing", FRAME_LEN, i - last);
        last = i;
      end
    end
    check("sync seen", 1, {31'h0, last >= 0});
    check("sync pin enabled", 1, {31'h0, fs_oe});
    wait_rx(8'h96);
    tx_valid = 1;
    tx_data = 8'h3C;
    @(negedge ref_clk);
    tx_valid = 0;
    wait_word(8'h3C);
  endtask
  initial begin
    do_reset(1'b0);
    check("sync pin off", 0, {31'h0, fs_oe});
    wait_rx(8'hA5);
    t_fill();
    t_master();
    check("pin faults", 0, bad_cnt);
    stop_test();
  end
endmodule
`default_nettype wire
